// file: hw/pcstx_top.sv
// transmit path: ddr capture, rate-matching fifo, 64b/66b, gearbox
// assumes all pins asynchronous to mclk and slow against it (<= 25 MHz)
`include "pcstx_params.svh"
module pcstx_top (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        testMode,
	input  wire logic        ipgModeSelect,
	input  wire logic        txDdrClock,
	input  wire logic [31:0] txWordIn,
	input  wire logic [3:0]  txByteCtrlIn,
	input  wire logic        lineTxRefClock,
	output logic             lineTxClock,
	output logic [15:0]      lineTxWord
);
	import pcstx_pkg::*;

	// =====================================================
	// helpers
	function automatic logic hasChar(input pcstx_unit_t u,
		input logic [7:0] ch);
		logic [63:0] d;
		logic [7:0]  c;
		logic        hit;
		d = {u.hi.data, u.lo.data};
		c = {u.hi.ctrl, u.lo.ctrl};
		hit = 1'b0;
		for (int i = 0; i < 8; i++) begin
			hit = hit | (c[i] & (d[8*i +: 8] == ch));
		end
		return hit;
	endfunction : hasChar

	function automatic logic allIdle(input pcstx_unit_t u);
		logic [63:0] d;
		logic        ok;
		d = {u.hi.data, u.lo.data};
		ok = ({u.hi.ctrl, u.lo.ctrl} == 8'hff);
		for (int i = 0; i < 8; i++) begin
			ok = ok & (d[8*i +: 8] == `PCSTX_CH_IDLE);
		end
		return ok;
	endfunction : allIdle

	function automatic pcstx_frm_t nextFrame(input pcstx_frm_t s,
		input pcstx_unit_t u);
		pcstx_frm_t r;
		r = s;
		if (hasChar(u, `PCSTX_CH_TERM)) begin
			r = FRM_GAP;
		end else if (hasChar(u, `PCSTX_CH_START)) begin
			r = FRM_PKT;
		end
		return r;
	endfunction : nextFrame

	function automatic logic [7:0] termType(input logic [2:0] k);
		logic [7:0] t;
		unique case (k)
			3'h0: t = `PCSTX_BT_TERM0;
			3'h1: t = `PCSTX_BT_TERM1;
			3'h2: t = `PCSTX_BT_TERM2;
			3'h3: t = `PCSTX_BT_TERM3;
			3'h4: t = `PCSTX_BT_TERM4;
			3'h5: t = `PCSTX_BT_TERM5;
			3'h6: t = `PCSTX_BT_TERM6;
			3'h7: t = `PCSTX_BT_TERM7;
		endcase
		return t;
	endfunction : termType

	// data, idle, start in lane 0 and terminate blocks; rest is error
	function automatic pcstx_code_t encode(input pcstx_unit_t u);
		logic [63:0] d;
		logic [7:0]  c;
		logic [63:0] p;
		logic        ok;
		logic        found;
		pcstx_code_t r;
		d = {u.hi.data, u.lo.data};
		c = {u.hi.ctrl, u.lo.ctrl};
		found = 1'b0;
		p = '0;
		r.sync = `PCSTX_SYNC_CTRL;
		r.payload = {{8{`PCSTX_CC_ERR}}, `PCSTX_BT_IDLE};
		if (c == 8'h00) begin
			r.sync = `PCSTX_SYNC_DATA;
			r.payload = d;
		end else if (allIdle(u)) begin
			r.payload = {56'h0, `PCSTX_BT_IDLE};
		end else if (c == 8'h01 && d[7:0] == `PCSTX_CH_START) begin
			r.payload = {d[63:8], `PCSTX_BT_START};
		end else begin
			for (int k = 0; k < 8; k++) begin
				ok = c[k] & (d[8*k +: 8] == `PCSTX_CH_TERM);
				for (int j = 0; j < 8; j++) begin
					if (j < k) begin
						ok = ok & ~c[j];
					end else if (j > k) begin
						ok = ok & c[j] & (d[8*j +: 8] == `PCSTX_CH_IDLE);
					end
				end
				if (ok && !found) begin
					p = '0;
					for (int j = 0; j < k; j++) begin
						p[8*(j+1) +: 8] = d[8*j +: 8];
					end
					p[7:0] = termType(3'(k));
					r.payload = p;
					found = 1'b1;
				end
			end
		end
		return r;
	endfunction : encode

	function automatic pcstx_scr_t scramble(input logic [63:0] din,
		input logic [57:0] s0);
		pcstx_scr_t r;
		logic       b;
		r.state = s0;
		r.out = '0;
		for (int i = 0; i < 64; i++) begin
			b = din[i] ^ r.state[`PCSTX_SCR_TAP_A]
				^ r.state[`PCSTX_SCR_TAP_B];
			r.out[i] = b;
			r.state = {r.state[56:0], b};
		end
		return r;
	endfunction : scramble

	// =====================================================
	// pin synchronisers
	logic [39:0] syncA;
	logic [39:0] syncB;
	logic        ddrPrev;
	logic        refPrev;
	logic        ddrS;
	logic        refS;
	logic        testS;
	logic        ipgS;
	pcstx_xfer_t xferS;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			syncA <= '0;
			syncB <= '0;
			ddrPrev <= 1'b0;
			refPrev <= 1'b0;
		end else begin
			syncA <= {txDdrClock, lineTxRefClock, testMode, ipgModeSelect,
				txByteCtrlIn, txWordIn};
			syncB <= syncA;
			ddrPrev <= ddrS;
			refPrev <= refS;
		end
	end

	assign ddrS = syncB[39];
	assign refS = syncB[38];
	assign testS = syncB[37];
	assign ipgS = syncB[36];
	assign xferS = syncB[35:0];

	// =====================================================
	// ddr input register: rising edge then falling edge
	pcstx_xfer_t loHold;
	pcstx_unit_t unitIn;
	logic        unitStb;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			loHold <= '0;
			unitIn <= '0;
			unitStb <= 1'b0;
		end else begin
			unitStb <= 1'b0;
			if (ddrS && !ddrPrev) begin
				loHold <= xferS;
			end
			if (!ddrS && ddrPrev) begin
				unitIn <= '{hi: xferS, lo: loHold};
				unitStb <= 1'b1;
			end
		end
	end

	// =====================================================
	// fifo with idle deletion on the write side
	logic [3:0]  wrPtr;
	logic [3:0]  rdPtr;
	logic [3:0]  fill;
	logic [3:0]  delMark;
	logic        doWrite;
	logic        doRead;
	pcstx_frm_t  wrFrm;
	pcstx_unit_t ramData;

	assign fill = wrPtr - rdPtr;
	// aggressive mode trims the gap early, standard only near full
	assign delMark = ipgS ? `PCSTX_DEL_AGR : `PCSTX_DEL_STD;
	assign doWrite = unitStb && fill != `PCSTX_FIFO_DEPTH
		&& !(wrFrm == FRM_GAP && allIdle(unitIn)
		&& fill >= delMark);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr <= '0;
			wrFrm <= FRM_GAP;
		end else if (unitStb) begin
			wrFrm <= nextFrame(wrFrm, unitIn);
			if (doWrite) begin
				wrPtr <= wrPtr + 4'h1;
			end
		end
	end

	pcstx_ram u_ram (
		.mclk   (mclk),
		.arst_n (arst_n),
		.wrEn   (doWrite),
		.wrAddr (wrPtr[2:0]),
		.wrData (unitIn),
		.rdEn   (doRead),
		.rdAddr (rdPtr[2:0]),
		.rdData (ramData)
	);

	// =====================================================
	// encoder and scrambler, idle insertion on the read side
	logic        codeValid;
	pcstx_code_t codeWord;
	logic [57:0] scrState;
	logic        rdPending;
	logic        fillPending;
	pcstx_frm_t  rdFrm;
	logic [95:0] gbBuf;
	logic [6:0]  gbCount;
	logic        gbLoad;
	logic        gbTake;
	pcstx_unit_t fillUnit;
	pcstx_unit_t encIn;
	pcstx_code_t encOut;
	pcstx_scr_t  scrOut;
	logic        fetch;

	assign fetch = !codeValid && !rdPending && !fillPending;
	assign doRead = fetch && fill != 4'h0;
	// underrun inside a frame cannot be hidden, so flag it as error
	assign fillUnit = (rdFrm == FRM_GAP)
		? {2{4'hf, {4{`PCSTX_CH_IDLE}}}}
		: {2{4'hf, {4{`PCSTX_CH_ERR}}}};
	assign encIn = fillPending ? fillUnit : ramData;
	assign encOut = encode(encIn);
	assign scrOut = scramble(encOut.payload, scrState);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdPtr <= '0;
			rdPending <= 1'b0;
			fillPending <= 1'b0;
			rdFrm <= FRM_GAP;
			codeValid <= 1'b0;
			codeWord <= '0;
			scrState <= `PCSTX_SCR_INIT;
		end else begin
			rdPending <= doRead;
			fillPending <= fetch && fill == 4'h0
				&& gbCount < `PCSTX_GB_HUNGRY;
			if (doRead) begin
				rdPtr <= rdPtr + 4'h1;
			end
			if (rdPending) begin
				rdFrm <= nextFrame(rdFrm, ramData);
			end
			if (rdPending || fillPending) begin
				codeWord <= '{payload: scrOut.out,
					sync: encOut.sync};
				scrState <= scrOut.state;
				codeValid <= 1'b1;
			end else if (gbLoad) begin
				codeValid <= 1'b0;
			end
		end
	end

	// =====================================================
	// gearbox and line output on reference clock edges
	assign gbLoad = codeValid && gbCount <= `PCSTX_GB_LOAD;
	assign gbTake = refS && !refPrev && gbCount >= `PCSTX_GB_WORD;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gbBuf <= '0;
			gbCount <= '0;
		end else begin
			unique case ({gbTake, gbLoad})
				2'b10: begin
					gbBuf <= gbBuf >> 16;
					gbCount <= gbCount - `PCSTX_GB_WORD;
				end
				2'b01: begin
					gbBuf <= gbBuf | ({30'h0, codeWord} << gbCount);
					gbCount <= gbCount + 7'h42;
				end
				2'b11: begin
					gbBuf <= (gbBuf >> 16) | ({30'h0, codeWord}
						<< (gbCount - `PCSTX_GB_WORD));
					gbCount <= gbCount + 7'h32;
				end
				2'b00: begin
					gbBuf <= gbBuf;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lineTxClock <= 1'b0;
			lineTxWord <= '0;
		end else begin
			lineTxClock <= refS;
			if (refS && !refPrev) begin
				if (testS) begin
					lineTxWord <= ~lineTxWord;
				end else if (gbTake) begin
					lineTxWord <= gbBuf[15:0];
				end
			end
		end
	end

endmodule : pcstx_top

// file: hw/pcstx_params.svh
// constants of the 10G PCS transmit path: codes, marks, reset values
// assumes inclusion by the top design file and by the bench only
`ifndef PCSTX_PARAMS_SVH
`define PCSTX_PARAMS_SVH

// xgmii control characters
`define PCSTX_CH_IDLE    8'h07
`define PCSTX_CH_START   8'hfb
`define PCSTX_CH_TERM    8'hfd
`define PCSTX_CH_ERR     8'hfe

// 64b/66b block types and 7-bit control codes
`define PCSTX_BT_IDLE    8'h1e
`define PCSTX_BT_START   8'h78
`define PCSTX_BT_TERM0   8'h87
`define PCSTX_BT_TERM1   8'h99
`define PCSTX_BT_TERM2   8'haa
`define PCSTX_BT_TERM3   8'hb4
`define PCSTX_BT_TERM4   8'hcc
`define PCSTX_BT_TERM5   8'hd2
`define PCSTX_BT_TERM6   8'he1
`define PCSTX_BT_TERM7   8'hff
`define PCSTX_CC_ERR     7'h1e

// sync header, bit 0 leaves first
`define PCSTX_SYNC_DATA  2'b10
`define PCSTX_SYNC_CTRL  2'b01

// scrambler taps (state bit index) and reset value
`define PCSTX_SCR_TAP_A  38
`define PCSTX_SCR_TAP_B  57
`define PCSTX_SCR_INIT   58'h3ffffffffffffff

// fifo: 8 units of 72 bits, 4-bit pointers
`define PCSTX_FIFO_DEPTH 4'h8
`define PCSTX_DEL_STD    4'h6
`define PCSTX_DEL_AGR    4'h4

// gearbox: 96-bit buffer, load limit, hunger mark, word width
`define PCSTX_GB_LOAD    7'h1e
`define PCSTX_GB_HUNGRY  7'h20
`define PCSTX_GB_WORD    7'h10

`endif

// file: hw/pcstx_pkg.sv
// types shared by the transmit path modules
// assumes pcstx_params.svh on the include path
package pcstx_pkg;

	typedef struct packed {
		logic [3:0]  ctrl;
		logic [31:0] data;
	} pcstx_xfer_t;

	// two transfers, lane 0 of lo is the first byte
	typedef struct packed {
		pcstx_xfer_t hi;
		pcstx_xfer_t lo;
	} pcstx_unit_t;

	typedef struct packed {
		logic [63:0] payload;
		logic [1:0]  sync;
	} pcstx_code_t;

	typedef struct packed {
		logic [57:0] state;
		logic [63:0] out;
	} pcstx_scr_t;

	typedef enum logic [1:0] {
		FRM_GAP = 2'b01,
		FRM_PKT = 2'b10
	} pcstx_frm_t;

endpackage : pcstx_pkg

// file: hw/pcstx_ram.sv
// fifo storage: 8 words of one transfer pair, registered read data
// assumes one writer and one reader on mclk, pointers kept outside
module pcstx_ram (
	input  wire logic                 mclk,
	input  wire logic                 arst_n,
	input  wire logic                 wrEn,
	input  wire logic [2:0]           wrAddr,
	input  wire pcstx_pkg::pcstx_unit_t wrData,
	input  wire logic                 rdEn,
	input  wire logic [2:0]           rdAddr,
	output pcstx_pkg::pcstx_unit_t    rdData
);
	import pcstx_pkg::*;

	pcstx_unit_t mem [0:7];

	always_ff @(posedge mclk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdData <= '0;
		end else if (rdEn) begin
			rdData <= mem[rdAddr];
		end
	end

endmodule : pcstx_ram

// file: tb/pcstx_monitor.sv
// checker of the transmit path output pins
// assumes a bind onto pcstx_top, every pin sampled on mclk
module pcstx_monitor (
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic        testMode,
	input wire logic        lineTxRefClock,
	input wire logic        lineTxClock,
	input wire logic [15:0] lineTxWord
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// assertions
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_reset_clears_out: assert property ($rose(arst_n) |->
		lineTxWord == 16'h0000 && !lineTxClock) else $error("out not reset");
	a_reset_sync_hold: assert property ($rose(arst_n) |=> !lineTxClock)
		else $error("clock too soon");
	a_clk_rise_follow: assert property ($rose(lineTxRefClock) &&
		$past(arst_n) |-> ##[1:4] $rose(lineTxClock)) else $error("no rise");
	a_clk_fall_follow: assert property ($fell(lineTxRefClock) &&
		$past(arst_n) |-> ##[1:4] $fell(lineTxClock)) else $error("no fall");
	a_clk_no_spur: assert property ($rose(lineTxClock) |->
		$past(lineTxRefClock, 2)) else $error("stray rise");
	a_word_on_clock: assert property ($changed(lineTxWord) |->
		$rose(lineTxClock)) else $error("word off clock");
	a_word_low_hold: assert property ($fell(lineTxClock) |->
		$stable(lineTxWord) [*3]) else $error("word moved");
	a_test_inverts: assert property ($rose(lineTxClock) && testMode &&
		$past(testMode, 12) |-> lineTxWord == ~$past(lineTxWord))
		else $error("test word");
	cover property ($rose(lineTxClock));
	cover property (testMode && $rose(lineTxClock));
	cover property ($rose(arst_n));
endmodule : pcstx_monitor

// file: tb/pcstx_mac_model.sv
// mac stand-in: one transfer pair per ddr clock period
// assumes pend is filled by the bench; sends idles when it runs dry
module pcstx_mac_model (
	input  wire logic   mclk,
	input  wire logic   arst_n,
	output logic        txDdrClock,
	output logic [31:0] txWordIn,
	output logic [3:0]  txByteCtrlIn
);
	timeunit 1ns;
	timeprecision 1ps;
	import pcstx_pkg::*;
	pcstx_unit_t pend[$];
	pcstx_unit_t cur;
	// ==========================================
	// 32 mclk per pair, slightly faster than the line drains
	initial begin
		txDdrClock = 1'b0;
		{txByteCtrlIn, txWordIn} = 36'hf_07070707;
		@(posedge arst_n);
		forever begin
			cur = pend.size() > 0 ? pend.pop_front() : {2{36'hf_07070707}};
			{txByteCtrlIn, txWordIn} = cur.lo;
			repeat (8) @(negedge mclk);
			txDdrClock = 1'b1;
			repeat (8) @(negedge mclk);
			{txByteCtrlIn, txWordIn} = cur.hi;
			repeat (8) @(negedge mclk);
			txDdrClock = 1'b0;
			repeat (8) @(negedge mclk);
		end
	end
endmodule : pcstx_mac_model

// file: tb/tb_top.sv
// self-checking bench of the transmit path
// assumes hw/ files, the mac model and the monitor are compiled first
`include "pcstx_params.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
	$display("mismatch %s expected %h seen %h", n, e, s); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        testMode = 1'b0;
	logic        ipgModeSelect = 1'b0;
	logic        prevClk = 1'b0;
	logic [2:0]  refCnt = 3'h0;
	logic        txDdrClock;
	logic        lineTxClock;
	logic [31:0] txWordIn;
	logic [3:0]  txByteCtrlIn;
	logic [15:0] lineTxWord;
	int          err_total = 0;
	int          checked = 0;
	logic        bq[$];
	logic [65:0] blk[$];
	wire         lineTxRefClock = refCnt[2];

	initial forever #5 mclk = ~mclk;
	// ==========================================
	// line clock at 8 mclk, stream capture on its rise
	always @(negedge mclk) begin
		refCnt <= arst_n ? refCnt + 3'h1 : 3'h0;
		prevClk <= lineTxClock;
		if (lineTxClock && !prevClk)
			for (int i = 0; i < 16; i++)
				bq.push_back(lineTxWord[i]);
	end

	pcstx_top i_pcstx_top (.mclk(mclk), .arst_n(arst_n), .testMode(testMode),
		.ipgModeSelect(ipgModeSelect), .txDdrClock(txDdrClock),
		.txWordIn(txWordIn), .txByteCtrlIn(txByteCtrlIn),
		.lineTxRefClock(lineTxRefClock), .lineTxClock(lineTxClock),
		.lineTxWord(lineTxWord));
	pcstx_mac_model i_pcstx_mac_model (.mclk(mclk), .arst_n(arst_n),
		.txDdrClock(txDdrClock), .txWordIn(txWordIn),
		.txByteCtrlIn(txByteCtrlIn));

	// ==========================================
	// block alignment on headers, then self-synchronising descramble
	task automatic decode();
		int          o;
		logic        r;
		logic [57:0] s;
		logic [65:0] w;
		for (o = 0; o < 66; o++) begin
			r = 1'b1;
			for (int k = o; k + 66 <= bq.size(); k += 66)
				if (bq[k] == bq[k+1]) r = 1'b0;
			if (r) break;
		end
		s = '1;
		blk.delete();
		for (int k = o; k + 66 <= bq.size(); k += 66) begin
			for (int i = 0; i < 66; i++) w[i] = bq[k+i];
			for (int i = 2; i < 66; i++) begin
				r = w[i];
				w[i] = r ^ s[`PCSTX_SCR_TAP_A] ^ s[`PCSTX_SCR_TAP_B];
				s = {s[56:0], r};
			end
			blk.push_back(w);
		end
	endtask : decode

	task automatic t_reset();
		`CHK("word in reset", 16'h0000, lineTxWord)
		`CHK("clock in reset", 1'b0, lineTxClock)
		arst_n = 1'b1;
		@(negedge mclk);
		`CHK("word after reset", 16'h0000, lineTxWord)
		$display("test reset done");
	endtask : t_reset

	task automatic t_idle(input logic mode);
		ipgModeSelect = mode;
		repeat (40) @(negedge mclk);
		bq.delete();
		repeat (640) @(negedge mclk);
		decode();
		`CHK("block count", 1'b1, blk.size() > 8)
		for (int k = 1; k < blk.size(); k++)
			`CHK("idle", {56'h0, `PCSTX_BT_IDLE, 2'b01}, blk[k])
		$display("test idle done");
	endtask : t_idle

	// start, data, bad control mix, data, terminate in aggressive mode
	task automatic t_frame();
		logic [65:0] want[5];
		int          at = -1;
		want = '{{64'h0706050403020178, 2'b01}, {64'h0f0e0d0c0b0a0908, 2'b10},
			{{8{`PCSTX_CC_ERR}}, `PCSTX_BT_IDLE, 2'b01},
			{64'h0f0e0d0c0b0a0908, 2'b10}, {64'h87, 2'b01}};
		ipgModeSelect = 1'b1;
		bq.delete();
		i_pcstx_mac_model.pend = '{{36'h0_07060504, 36'h1_030201fb},
			{36'h0_0f0e0d0c, 36'h0_0b0a0908}, {36'h1_070707fb, 36'h0_0b0a0908},
			{36'h0_0f0e0d0c, 36'h0_0b0a0908}, {36'hf_07070707, 36'hf_070707fd}};
		repeat (900) @(negedge mclk);
		decode();
		foreach (blk[k])
			if (at < 0 && blk[k][9:0] == {8'h78, 2'b01}) at = k;
		`CHK("start block", 1'b1, at > 0 && at + 4 < blk.size())
		if (at > 0 && at + 4 < blk.size())
			for (int i = 0; i < 5; i++)
				`CHK("frame block", want[i], blk[at+i])
		$display("test frame done");
	endtask : t_frame

	task automatic t_test();
		logic [15:0] a;
		logic [15:0] b;
		testMode = 1'b1;
		repeat (40) @(negedge mclk);
		bq.delete();
		repeat (80) @(negedge mclk);
		for (int k = 16; k + 16 <= bq.size(); k += 16) begin
			for (int i = 0; i < 16; i++) begin
				a[i] = bq[k-16+i];
				b[i] = bq[k+i];
			end
			`CHK("test word", ~a, b)
		end
		testMode = 1'b0;
		$display("test mode done");
	endtask : t_test

	// reset in mid-stream must drop queued units and gearbox bits
	task automatic t_midreset();
		repeat (100) @(negedge mclk);
		arst_n = 1'b0;
		repeat (3) @(negedge mclk);
		`CHK("word in mid reset", 16'h0000, lineTxWord)
		`CHK("clock in mid reset", 1'b0, lineTxClock)
		`CHK("fifo fill in reset", 4'h0, i_pcstx_top.fill)
		`CHK("gearbox in reset", 7'h00, i_pcstx_top.gbCount)
		arst_n = 1'b1;
		@(negedge mclk);
		`CHK("word after mid reset", 16'h0000, lineTxWord)
		$display("test mid reset done");
	endtask : t_midreset

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	initial begin
		repeat (20) @(negedge mclk);
		t_reset();
		t_idle(1'b0);
		t_frame();
		t_test();
		t_midreset();
		t_idle(1'b0);
		complete_run();
	end
endmodule : tb_top

bind pcstx_top pcstx_monitor i_pcstx_monitor (.mclk(mclk), .arst_n(arst_n),
	.testMode(testMode), .lineTxRefClock(lineTxRefClock),
	.lineTxClock(lineTxClock), .lineTxWord(lineTxWord));
